/* plw_long_write_ctrl.sv */
// long-write controller for one-time-programmable program memory
//
// Contract
// - even-pointer table write copies the latch into the hidden holding byte
// - long write puts latch in high byte, holding byte in low byte
// - odd-byte table write halts core and applies voltage and data
// - long write needs programming voltage, enable bit set, odd address
// - enable bit clear: odd write is short, array untouched
// - write not to the odd byte never starts programming
// - enable bit cannot be cleared by software, only by reset
// - long write ends only by reset or interrupt
// - enabled source's flag ends programming whatever priority or globals
// - ending leaves the causing flag set until software clears it
// - disabled source's flag does not end the write
// - enabled source with clear flag: continue, wake when flag sets
// - resume in line when globals disallow the source's level
// - low global set, high clear, low source: low-priority vector
// - high global set, low clear, high source: high-priority vector
//
// The address-and-strobe port and the register addresses were left to the implementer.
`timescale 1ns/1ps
`default_nettype none
`include "plw_map.svh"

module plw_long_write_ctrl
    import plw_pkg::*;
(
    // clock and reset
    input  wire logic                  core_clk_i,
    input  wire logic                  reset_i,
    // register port
    input  wire logic [`PLW_ADDR_W-1:0] reg_addr_i,
    input  wire logic [7:0]            reg_wdata_i,
    input  wire logic                  reg_wr_i,
    input  wire logic                  reg_rd_i,
    output logic      [7:0]            reg_rdata_o,
    // core side
    input  wire logic                  table_write_instr_i,
    input  wire logic                  master_clear_prog_voltage_pin_i,
    input  wire logic                  int_flag_set_i,
    output logic                       core_halt_o,
    output logic                       resume_valid_o,
    output plw_resume_t                resume_kind_o,
    // array side
    output logic                       prog_voltage_en_o,
    output plw_prog_word_t             prog_word_o
);

    // ------------------------------------------------------------------------
    // state
    // ------------------------------------------------------------------------
    plw_state_t  state;
    plw_state_t  next_state;
    logic        long_write_enable;
    logic        int_prio_en;
    logic        src_enable;
    logic        src_flag;
    logic        src_high_pri;
    logic        global_high_int_enable;
    logic        peripheral_low_int_enable;
    logic [7:0]  table_latch;
    logic [21:0] table_pointer;
    logic [7:0]  hold_byte;
    logic        hold_valid;

    // control register reset image, sliced per bit at reset
    localparam logic [7:0] CTRL_RST = `PLW_CTRL_RST;

    // ------------------------------------------------------------------------
    // decode
    // ------------------------------------------------------------------------
    wire wr_ctrl   = reg_wr_i && (reg_addr_i == `PLW_REG_CTRL);
    wire wr_latch  = reg_wr_i && (reg_addr_i == `PLW_REG_TLATCH);
    wire wr_ptr_l  = reg_wr_i && (reg_addr_i == `PLW_REG_PTR_L);
    wire wr_ptr_h  = reg_wr_i && (reg_addr_i == `PLW_REG_PTR_H);
    wire wr_ptr_u  = reg_wr_i && (reg_addr_i == `PLW_REG_PTR_U);
    wire wr_intsrc = reg_wr_i && (reg_addr_i == `PLW_REG_INTSRC);

    wire idle      = (state == PLW_IDLE);
    wire twr       = table_write_instr_i && idle;
    wire ptr_odd   = table_pointer[0];
    wire short_wr  = twr && (!ptr_odd || !long_write_enable
                     || !master_clear_prog_voltage_pin_i);
    wire even_wr   = twr && !ptr_odd;
    wire start_lw  = twr && ptr_odd && long_write_enable
                     && master_clear_prog_voltage_pin_i;
    // only an enabled source with its flag set ends the write
    wire flag_now  = src_flag || int_flag_set_i;
    wire terminate = (state == PLW_PROG) && src_enable
                     && flag_now;

    // resume decision from globals and priority
    wire go_low    = !global_high_int_enable && peripheral_low_int_enable
                     && !src_high_pri;
    wire go_high   = global_high_int_enable && !peripheral_low_int_enable
                     && src_high_pri;
    wire [1:0] resume_sel = go_high ? 2'h2 : (go_low ? 2'h1 : 2'h0);

    // ------------------------------------------------------------------------
    // next state
    // ------------------------------------------------------------------------
    always_comb begin
        next_state = state;
        unique case (state)
            PLW_IDLE: begin
                if (start_lw) begin
                    next_state = PLW_PROG;
                end
            end
            PLW_PROG: begin
                if (terminate) begin
                    next_state = PLW_DONE;
                end
            end
            PLW_DONE: begin
                next_state = PLW_IDLE;
            end
            // the fourth code is unused; fall back to idle
            default: begin
                next_state = PLW_IDLE;
            end
        endcase
    end

    // ------------------------------------------------------------------------
    // state register; reset drops everything at once
    // ------------------------------------------------------------------------
    always_ff @(posedge core_clk_i) begin
        if (reset_i) begin
            state <= PLW_IDLE;
        end else begin
            state <= next_state;
        end
    end

    // ------------------------------------------------------------------------
    // control bits: enable is sticky until reset
    // ------------------------------------------------------------------------
    always_ff @(posedge core_clk_i) begin
        if (reset_i) begin
            long_write_enable <= CTRL_RST[`PLW_CTRL_LWE_BIT];
            int_prio_en       <= CTRL_RST[`PLW_CTRL_PRIO_BIT];
        end else if (wr_ctrl) begin
            long_write_enable <= long_write_enable
                                 | reg_wdata_i[`PLW_CTRL_LWE_BIT];
            int_prio_en       <= reg_wdata_i[`PLW_CTRL_PRIO_BIT];
        end
    end

    // ------------------------------------------------------------------------
    // interrupt source bits; hardware set wins over software clear
    // ------------------------------------------------------------------------
    always_ff @(posedge core_clk_i) begin
        if (reset_i) begin
            src_enable                <= 1'b0;
            src_flag                  <= 1'b0;
            src_high_pri              <= 1'b1;
            global_high_int_enable    <= 1'b0;
            peripheral_low_int_enable <= 1'b0;
        end else begin
            if (wr_intsrc) begin
                src_enable                <= reg_wdata_i[`PLW_INT_EN_BIT];
                src_high_pri              <= reg_wdata_i[`PLW_INT_HIPRI_BIT];
                global_high_int_enable    <= reg_wdata_i[`PLW_INT_GH_BIT];
                peripheral_low_int_enable <= reg_wdata_i[`PLW_INT_GL_BIT];
            end
            // flag stays set through termination
            src_flag <= int_flag_set_i || (wr_intsrc
                        ? reg_wdata_i[`PLW_INT_FLAG_BIT] : src_flag);
        end
    end

    // ------------------------------------------------------------------------
    // table latch and pointer
    // ------------------------------------------------------------------------
    always_ff @(posedge core_clk_i) begin
        if (reset_i) begin
            table_latch   <= `PLW_BYTE_RST;
            table_pointer <= 22'h000000;
        end else begin
            if (wr_latch) table_latch <= reg_wdata_i;
            if (wr_ptr_l) table_pointer[7:0] <= reg_wdata_i;
            if (wr_ptr_h) table_pointer[15:8] <= reg_wdata_i;
            if (wr_ptr_u) table_pointer[21:16] <= reg_wdata_i[5:0];
        end
    end

    // ------------------------------------------------------------------------
    // hidden holding byte, loaded by an even short write
    // ------------------------------------------------------------------------
    always_ff @(posedge core_clk_i) begin
        if (reset_i) begin
            hold_byte  <= `PLW_BYTE_RST;
            hold_valid <= 1'b0;
        end else if (even_wr) begin
            hold_byte  <= table_latch;
            hold_valid <= 1'b1;
        end else if (start_lw) begin
            hold_valid <= 1'b0;
        end
    end

    // ------------------------------------------------------------------------
    // word presented to the array, captured at start of a long write
    // ------------------------------------------------------------------------
    always_ff @(posedge core_clk_i) begin
        if (reset_i) begin
            prog_word_o <= '0;
        end else if (start_lw) begin
            prog_word_o.block_addr <= table_pointer[21:1];
            prog_word_o.high_byte  <= table_latch;
            prog_word_o.low_byte   <= hold_byte;
        end
    end

    // ------------------------------------------------------------------------
    // resume report, one pulse after the write ends
    // ------------------------------------------------------------------------
    always_ff @(posedge core_clk_i) begin
        if (reset_i) begin
            resume_valid_o <= 1'b0;
            resume_kind_o  <= PLW_RES_NEXT;
        end else begin
            resume_valid_o <= terminate;
            if (terminate) begin
                resume_kind_o <= plw_resume_t'(resume_sel);
            end
        end
    end

    // halt and voltage only while programming
    assign core_halt_o       = (state == PLW_PROG);
    assign prog_voltage_en_o = (state == PLW_PROG);

    // ------------------------------------------------------------------------
    // read data, one cycle after the strobe
    // ------------------------------------------------------------------------
    wire [7:0] ctrl_rd   = {int_prio_en, long_write_enable, 6'h00};
    wire [7:0] status_rd = {5'h00, hold_valid, core_halt_o, !idle};
    wire [7:0] intsrc_rd = {3'h0, peripheral_low_int_enable,
                            global_high_int_enable, src_high_pri,
                            src_flag, src_enable};
    wire [7:0] rd_mux =
        (reg_addr_i == `PLW_REG_CTRL)   ? ctrl_rd :
        (reg_addr_i == `PLW_REG_STATUS) ? status_rd :
        (reg_addr_i == `PLW_REG_TLATCH) ? table_latch :
        (reg_addr_i == `PLW_REG_PTR_L)  ? table_pointer[7:0] :
        (reg_addr_i == `PLW_REG_PTR_H)  ? table_pointer[15:8] :
        (reg_addr_i == `PLW_REG_PTR_U)  ? {2'h0, table_pointer[21:16]} :
        (reg_addr_i == `PLW_REG_INTSRC) ? intsrc_rd : 8'h00;

    always_ff @(posedge core_clk_i) begin
        if (reset_i) begin
            reg_rdata_o <= 8'h00;
        end else begin
            reg_rdata_o <= reg_rd_i ? rd_mux : 8'h00;
        end
    end

    // ------------------------------------------------------------------------
    // assertions
    // ------------------------------------------------------------------------
    sequence s_odd_armed;
        twr && ptr_odd && long_write_enable && master_clear_prog_voltage_pin_i;
    endsequence

    a_long_write_start: assert property (@(posedge core_clk_i)
        disable iff (reset_i) s_odd_armed |=> core_halt_o && prog_voltage_en_o)
        else $error("long write did not start");
    a_no_start_even: assert property (@(posedge core_clk_i)
        disable iff (reset_i) (idle && !start_lw) |=> !core_halt_o)
        else $error("halt without a qualified odd write");
    a_word_bytes: assert property (@(posedge core_clk_i)
        disable iff (reset_i) start_lw |=> prog_word_o.high_byte
        == $past(table_latch) && prog_word_o.low_byte == $past(hold_byte))
        else $error("array bytes in wrong order");
    a_hold_load: assert property (@(posedge core_clk_i)
        disable iff (reset_i) even_wr |=> hold_byte == $past(table_latch))
        else $error("holding byte not loaded");
    a_enable_sticky: assert property (@(posedge core_clk_i)
        disable iff (reset_i) long_write_enable |=> long_write_enable)
        else $error("enable bit cleared without reset");
    a_halt_holds: assert property (@(posedge core_clk_i)
        disable iff (reset_i) (core_halt_o && !terminate) |=> core_halt_o)
        else $error("halt left without interrupt");
    a_terminate_ends: assert property (@(posedge core_clk_i)
        disable iff (reset_i) terminate |=> !core_halt_o ##1 !core_halt_o)
        else $error("enabled flag did not end write");
    a_flag_kept: assert property (@(posedge core_clk_i)
        disable iff (reset_i) (src_flag && !wr_intsrc) |=> src_flag)
        else $error("flag cleared by hardware");
    a_low_vector: assert property (@(posedge core_clk_i)
        disable iff (reset_i) (terminate && go_low) |=> resume_valid_o
        && resume_kind_o == PLW_RES_LOW_VEC)
        else $error("low vector not taken");
    a_high_vector: assert property (@(posedge core_clk_i)
        disable iff (reset_i) (terminate && go_high) |=> resume_valid_o
        && resume_kind_o == PLW_RES_HIGH_VEC)
        else $error("high vector not taken");
    a_inline_resume: assert property (@(posedge core_clk_i)
        disable iff (reset_i) (terminate && !go_low && !go_high)
        |=> resume_kind_o == PLW_RES_NEXT)
        else $error("in-line resume not taken");
    a_reset_idle: assert property (@(posedge core_clk_i)
        reset_i |=> !prog_voltage_en_o && !core_halt_o)
        else $error("reset left voltage applied");

endmodule
`default_nettype wire

/* plw_map.svh */
// offsets, field positions and reset values of the long-write controller
`ifndef PLW_MAP_SVH
`define PLW_MAP_SVH

// ----------------------------------------------------------------------------
// register offsets
// ----------------------------------------------------------------------------
`define PLW_ADDR_W          4
`define PLW_REG_CTRL        4'h0
`define PLW_REG_STATUS      4'h1
`define PLW_REG_TLATCH      4'h2
`define PLW_REG_PTR_L       4'h3
`define PLW_REG_PTR_H       4'h4
`define PLW_REG_PTR_U       4'h5
`define PLW_REG_INTSRC      4'h6

// ----------------------------------------------------------------------------
// field positions
// ----------------------------------------------------------------------------
`define PLW_CTRL_LWE_BIT    6
`define PLW_CTRL_PRIO_BIT   7
`define PLW_ST_BUSY_BIT     0
`define PLW_ST_HALT_BIT     1
`define PLW_ST_HOLD_BIT     2
`define PLW_INT_EN_BIT      0
`define PLW_INT_FLAG_BIT    1
`define PLW_INT_HIPRI_BIT   2
`define PLW_INT_GH_BIT      3
`define PLW_INT_GL_BIT      4

// ----------------------------------------------------------------------------
// reset values
// ----------------------------------------------------------------------------
`define PLW_CTRL_RST        8'h00
`define PLW_INTSRC_RST      8'h04
`define PLW_BYTE_RST        8'h00

`endif

/* plw_pkg.sv */
// types shared by the long-write controller
`default_nettype none
package plw_pkg;

    // controller states
    typedef enum logic [1:0] {
        PLW_IDLE,
        PLW_PROG,
        PLW_DONE
    } plw_state_t;

    // how execution resumes after a write is ended
    typedef enum logic [1:0] {
        PLW_RES_NEXT,
        PLW_RES_LOW_VEC,
        PLW_RES_HIGH_VEC,
        PLW_RES_RESET
    } plw_resume_t;

    // one array write: block address and its two bytes
    typedef struct packed {
        logic [20:0] block_addr;
        logic [7:0]  high_byte;
        logic [7:0]  low_byte;
    } plw_prog_word_t;

    // table write request from the core
    typedef struct packed {
        logic        valid;
        logic [21:0] ptr;
        logic [7:0]  data;
    } plw_twr_req_t;

endpackage
`default_nettype wire

/* plw_core_model.sv */
// core-side model: register bus master and table write issuer
`timescale 1ns/1ps
`default_nettype none
`include "plw_map.svh"

module plw_core_model (
    // clock
    input  wire logic                   core_clk_i,
    // register port
    output logic [`PLW_ADDR_W-1:0]      reg_addr_o,
    output logic [7:0]                  reg_wdata_o,
    output logic                        reg_wr_o,
    output logic                        reg_rd_o,
    input  wire logic [7:0]             reg_rdata_i,
    // table write strobe
    output logic                        table_write_instr_o
);
    // idle bus at time zero
    initial begin
        reg_addr_o = '0;
        reg_wdata_o = '0;
        reg_wr_o = 1'b0;
        reg_rd_o = 1'b0;
        table_write_instr_o = 1'b0;
    end

    // one-cycle write strobe
    task automatic reg_write(input logic [3:0] a, input logic [7:0] d);
        @(posedge core_clk_i);
        reg_addr_o <= a;
        reg_wdata_o <= d;
        reg_wr_o <= 1'b1;
        @(posedge core_clk_i);
        reg_wr_o <= 1'b0;
    endtask

    // read data stands only in the cycle after the strobe
    task automatic reg_read(input logic [3:0] a, output logic [7:0] d);
        @(posedge core_clk_i);
        reg_addr_o <= a;
        reg_rd_o <= 1'b1;
        @(posedge core_clk_i);
        reg_rd_o <= 1'b0;
        #1 d = reg_rdata_i;
    endtask

    // load latch and pointer, then issue one table write
    task automatic table_write(input logic [7:0] lat, input logic [21:0] p);
        reg_write(`PLW_REG_TLATCH, lat);
        reg_write(`PLW_REG_PTR_L, p[7:0]);
        reg_write(`PLW_REG_PTR_H, p[15:8]);
        reg_write(`PLW_REG_PTR_U, {2'b00, p[21:16]});
        @(posedge core_clk_i);
        table_write_instr_o <= 1'b1;
        @(posedge core_clk_i);
        table_write_instr_o <= 1'b0;
        #1;
    endtask

    // even byte first, then the odd byte of the same block
    task automatic write_block(input logic [7:0] lo, input logic [7:0] hi,
                               input logic [21:0] p);
        table_write(lo, {p[21:1], 1'b0});
        table_write(hi, {p[21:1], 1'b1});
    endtask
endmodule
`default_nettype wire

/* program_memory_long_write_ctrl_tb.sv */
// self-checking bench of the long-write controller
`timescale 1ns/1ps
`default_nettype none
`include "plw_map.svh"

module program_memory_long_write_ctrl_tb;
    import plw_pkg::*;
    logic core_clk_i = 1'b0;
    logic reset_i = 1'b1;
    logic pin = 1'b0;
    logic flag = 1'b0;
    logic [3:0] addr;
    logic [7:0] wdata, rdata, rv, lo, hi, cfg;
    logic wr, rd, twr, halt, rvalid, pv;
    plw_resume_t kind;
    plw_prog_word_t word;
    logic [31:0] lfsr = 32'h317e;
    int num_errors = 0;
    int n_compared = 0;

    plw_core_model i_core (.core_clk_i(core_clk_i), .reg_addr_o(addr),
        .reg_wdata_o(wdata), .reg_wr_o(wr), .reg_rd_o(rd),
        .reg_rdata_i(rdata), .table_write_instr_o(twr));

    plw_long_write_ctrl i_dut (.core_clk_i(core_clk_i), .reset_i(reset_i),
        .reg_addr_i(addr), .reg_wdata_i(wdata), .reg_wr_i(wr), .reg_rd_i(rd),
        .reg_rdata_o(rdata), .table_write_instr_i(twr),
        .master_clear_prog_voltage_pin_i(pin), .int_flag_set_i(flag),
        .core_halt_o(halt), .resume_valid_o(rvalid), .resume_kind_o(kind),
        .prog_voltage_en_o(pv), .prog_word_o(word));

    // 250 MHz clock
    initial begin
        forever #2 core_clk_i = ~core_clk_i;
    end

    // ------------------------------------------------------------------
    // helpers
    // ------------------------------------------------------------------
    function automatic logic [31:0] lfsr_next(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction

    // vector only when exactly the source's own level is enabled
    function automatic logic [1:0] exp_kind(input logic [7:0] c);
        if (c[3] && !c[4] && c[2]) return PLW_RES_HIGH_VEC;
        if (!c[3] && c[4] && !c[2]) return PLW_RES_LOW_VEC;
        return PLW_RES_NEXT;
    endfunction

    task automatic check(input string what, input logic [36:0] seen,
                         input logic [36:0] exp);
        n_compared++;
        if (seen !== exp) begin
            num_errors++;
            $display("ERROR %s expected %h seen %h", what, exp, seen);
        end
    endtask

    task automatic rd_check(input logic [3:0] a, input logic [7:0] exp);
        i_core.reg_read(a, rv);
        check("rdata", 37'(rv), 37'(exp));
    endtask

    // one flag pulse from the terminating source
    task automatic pulse_flag();
        @(posedge core_clk_i);
        flag <= 1'b1;
        @(posedge core_clk_i);
        flag <= 1'b0;
        #1;
    endtask

    task automatic finish_test();
        $display("errors %0d compared %0d", num_errors, n_compared);
        if (num_errors == 0 && n_compared > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask

    // watchdog
    initial begin
        repeat (20000) @(posedge core_clk_i);
        num_errors++;
        finish_test();
    end

    // ------------------------------------------------------------------
    // main sequence
    // ------------------------------------------------------------------
    initial begin
        repeat (20) @(posedge core_clk_i);
        reset_i <= 1'b0;
        rd_check(`PLW_REG_CTRL, `PLW_CTRL_RST);
        rd_check(`PLW_REG_INTSRC, `PLW_INTSRC_RST);
        rd_check(4'hf, 8'h00);
        pin <= 1'b1;
        i_core.write_block(8'h11, 8'h22, 22'h000010);
        check("halt", 37'(halt), 37'(0));
        i_core.reg_write(`PLW_REG_CTRL, 8'h40);
        i_core.reg_write(`PLW_REG_CTRL, 8'h80);
        rd_check(`PLW_REG_CTRL, 8'hc0);
        pin <= 1'b0;
        i_core.write_block(8'h33, 8'h44, 22'h000020);
        check("halt", 37'(halt), 37'(0));
        pin <= 1'b1;
        i_core.table_write(8'h55, 22'h000030);
        check("halt", 37'(halt), 37'(0));
        rd_check(`PLW_REG_STATUS, 8'h04);
        // disabled flag, in-line, low and high vector cases of the action table, then reset
        for (int i = 0; i < 6; i++) begin
            lfsr = lfsr_next(lfsr);
            lo = lfsr[7:0];
            hi = lfsr[15:8];
            case (i)
                0: cfg = {5'b0, lfsr[16], 2'b00};
                1: cfg = 8'h14;
                2: cfg = 8'h08;
                3: cfg = 8'h10;
                4: cfg = 8'h0c;
                default: cfg = 8'h00;
            endcase
            i_core.reg_write(`PLW_REG_INTSRC, cfg);
            i_core.write_block(lo, hi, lfsr[21:0]);
            check("halt", 37'(halt), 37'(1));
            check("volt", 37'(pv), 37'(1));
            check("high", 37'(word.high_byte), 37'(hi));
            check("low", 37'(word.low_byte), 37'(lo));
            check("addr", 37'(word.block_addr), 37'(lfsr[21:1]));
            if (i == 5) begin
                @(posedge core_clk_i);
                reset_i <= 1'b1;
                repeat (2) @(posedge core_clk_i);
                #1 check("halt", 37'(halt), 37'(0));
                check("volt", 37'(pv), 37'(0));
                @(posedge core_clk_i);
                reset_i <= 1'b0;
                rd_check(`PLW_REG_CTRL, 8'h00);
            end else begin
                if (i == 0) begin
                    pulse_flag();
                    check("halt", 37'(halt), 37'(1));
                    i_core.reg_write(`PLW_REG_INTSRC, cfg);
                end
                i_core.reg_write(`PLW_REG_INTSRC, cfg | 8'h01);
                repeat (3) @(posedge core_clk_i);
                #1 check("halt", 37'(halt), 37'(1));
                pulse_flag();
                check("halt", 37'(halt), 37'(0));
                check("resume", 37'(rvalid), 37'(1));
                check("kind", 37'(kind), 37'(exp_kind(cfg)));
                rd_check(`PLW_REG_INTSRC, cfg | 8'h03);
                i_core.reg_write(`PLW_REG_INTSRC, cfg);
            end
        end
        pin <= 1'b0;
        check("word", 37'(word), 37'(0));
        rd_check(`PLW_REG_STATUS, 8'h00);
        finish_test();
    end
endmodule
`default_nettype wire
